// file: nim_host.sv
// Flash host end: per-target interface switching sequencer
`timescale 1ns/1ps
module nim_host (
   input wire logic clk_sys,
   input wire logic rst_b,
   nim_link_if.host link,
   input wire logic req_valid,
   input wire nim_pkg::nim_iface_e req_iface,
   input wire logic [nim_pkg::TW-1:0] req_target,
   input wire logic [3:0] req_tm,
   input wire logic [7:0] req_cfg,
   output logic req_ready,
   output logic done,
   output logic init_done,
   output logic [nim_pkg::NT-1:0][1:0] cur_iface,
   output logic [nim_pkg::NT-1:0][3:0] cur_tm
);
   import nim_pkg::*;
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_PREP = 3'b001,
      H_SEND = 3'b010,
      H_WAIT_LO = 3'b011,
      H_WAIT_HI = 3'b100,
      H_CLKON = 3'b101,
      H_ADV = 3'b110
   } nim_hstate_e;

   nim_hstate_e st_q;
   nim_phase_e ph_q;
   nim_iface_e op_q;
   logic need_rst_q, need_cfg_q, need_sel_q;
   logic [3:0] tm_q;
   logic [7:0] cfg_q, cnt_q;
   logic [TW-1:0] tidx_q;
   logic [2:0] bidx_q;
   logic half_q;
   logic [NT-1:0] ce_n_q;
   logic we_n_q;
   logic clk_en_q;
   logic [1:0] div_q;
   logic nand_clk_q;
   logic init_q, done_q;
   logic [NT-1:0] rb_m_q, rb_s_q;
   logic [NT-1:0][1:0] cur_if_q;
   logic [NT-1:0][3:0] cur_tm_q;
   logic [9:0] byte_w;
   logic [2:0] last_w;
   logic [7:0] p1_w;
   logic in_async;

   assign in_async = (cur_if_q[req_target] == NIM_IF_ASYNC);
   assign p1_w = (ph_q == NIM_PH_CFG) ? cfg_q :
      {(op_q == NIM_IF_NVDDR2) ? P1_SEL_NVDDR2 : P1_SEL_NVDDR, tm_q};
   assign last_w = (ph_q == NIM_PH_RST) ? 3'd0 : 3'd5;

   always_comb begin
      byte_w = {2'b00, 8'h00};
      if (ph_q == NIM_PH_RST) begin
         byte_w = {2'b10, CMD_RESET};
      end else if (bidx_q == 3'd0) begin
         byte_w = {2'b10, CMD_SET_FEATURES};
      end else if (bidx_q == 3'd1) begin
         byte_w = {2'b01, (ph_q == NIM_PH_CFG) ? FEAT_NV2_CFG : FEAT_TIMING};
      end else if (bidx_q == 3'd2) begin
         byte_w = {2'b00, p1_w};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rb_m_q <= '0;
         rb_s_q <= '0;
      end else begin
         rb_m_q <= link.rb_n;
         rb_s_q <= rb_m_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= H_IDLE;
         ph_q <= NIM_PH_RST;
         op_q <= NIM_IF_ASYNC;
         need_rst_q <= 1'b0;
         need_cfg_q <= 1'b0;
         need_sel_q <= 1'b0;
         tm_q <= RST_TM;
         cfg_q <= RST_CFG;
         cnt_q <= 8'h00;
         tidx_q <= '0;
         bidx_q <= 3'd0;
         half_q <= 1'b0;
         ce_n_q <= '1;
         we_n_q <= 1'b1;
         clk_en_q <= 1'b0;
         init_q <= 1'b0;
         done_q <= 1'b0;
         cur_if_q <= '0;
         cur_tm_q <= '0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            H_IDLE: begin
               if (!init_q) begin
                  ph_q <= NIM_PH_RST;
                  st_q <= H_PREP;
                  cnt_q <= 8'h00;
               end else if (req_valid) begin
                  op_q <= req_iface;
                  tm_q <= req_tm;
                  cfg_q <= req_cfg;
                  tidx_q <= req_target;
                  // Leave any sync mode through async first
                  need_rst_q <= 1'b0;
                  need_cfg_q <= (req_iface == NIM_IF_NVDDR2);
                  need_sel_q <= (req_iface != NIM_IF_ASYNC);
                  if (req_iface == NIM_IF_ASYNC || !in_async) begin
                     ph_q <= NIM_PH_RST;
                     st_q <= H_PREP;
                  end else begin
                     ph_q <= (req_iface == NIM_IF_NVDDR2) ? NIM_PH_CFG : NIM_PH_SEL;
                     need_cfg_q <= 1'b0;
                     need_sel_q <= (req_iface == NIM_IF_NVDDR2);
                     st_q <= H_PREP;
                  end
                  cnt_q <= 8'h00;
               end
            end
            H_PREP: begin
               ce_n_q <= '1;
               if (ph_q == NIM_PH_RST) begin
                  clk_en_q <= 1'b0;
               end
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == CE_SETUP_CYC - 8'h01) begin
                  ce_n_q[tidx_q] <= 1'b0;
                  we_n_q <= 1'b0;
                  bidx_q <= 3'd0;
                  half_q <= 1'b0;
                  cnt_q <= 8'h00;
                  st_q <= H_SEND;
               end
            end
            H_SEND: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == STROBE_CYC - 8'h01) begin
                  cnt_q <= 8'h00;
                  half_q <= !half_q;
                  we_n_q <= !half_q;
                  if (half_q) begin
                     if (bidx_q == last_w) begin
                        we_n_q <= 1'b1;
                        ce_n_q <= '1;
                        st_q <= (ph_q == NIM_PH_CFG) ? H_ADV : H_WAIT_LO;
                     end else begin
                        bidx_q <= bidx_q + 3'd1;
                     end
                  end
               end
            end
            H_WAIT_LO: begin
               if (!rb_s_q[tidx_q]) begin
                  st_q <= H_WAIT_HI;
               end
            end
            H_WAIT_HI: begin
               if (rb_s_q[tidx_q]) begin
                  cnt_q <= 8'h00;
                  if (ph_q == NIM_PH_SEL) begin
                     cur_if_q[tidx_q] <= op_q;
                     cur_tm_q[tidx_q] <= tm_q;
                     clk_en_q <= 1'b1;
                     st_q <= H_CLKON;
                  end else begin
                     cur_if_q[tidx_q] <= NIM_IF_ASYNC;
                     cur_tm_q[tidx_q] <= RST_TM;
                     st_q <= H_ADV;
                  end
               end
            end
            H_CLKON: begin
               // Clock must run before the target is selected again
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == CE_SETUP_CYC - 8'h01) begin
                  st_q <= H_ADV;
               end
            end
            H_ADV: begin
               cnt_q <= 8'h00;
               if (need_cfg_q) begin
                  need_cfg_q <= 1'b0;
                  ph_q <= NIM_PH_CFG;
                  st_q <= H_PREP;
               end else if (need_sel_q) begin
                  need_sel_q <= 1'b0;
                  ph_q <= NIM_PH_SEL;
                  st_q <= H_PREP;
               end else begin
                  st_q <= H_IDLE;
                  if (!init_q) begin
                     if (tidx_q == TW'(NT - 1)) begin
                        init_q <= 1'b1;
                     end
                     tidx_q <= tidx_q + TW'(1);
                  end else begin
                     done_q <= 1'b1;
                  end
               end
            end
            default: begin
               st_q <= H_IDLE;
            end
         endcase
      end
   end

   // Shared sync clock pin; stands still while stopped
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 2'h0;
         nand_clk_q <= 1'b0;
      end else if (!clk_en_q) begin
         div_q <= 2'h0;
         nand_clk_q <= 1'b0;
      end else if (div_q == CLK_DIV - 2'h1) begin
         div_q <= 2'h0;
         nand_clk_q <= !nand_clk_q;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   assign link.ce_n = ce_n_q;
   assign link.cle = (st_q == H_SEND) && byte_w[9];
   assign link.ale = (st_q == H_SEND) && byte_w[8];
   assign link.dq = (st_q == H_SEND) ? byte_w[7:0] : 8'h00;
   assign link.we_n = we_n_q;
   assign link.nand_clk = nand_clk_q;
   assign req_ready = (st_q == H_IDLE) && init_q;
   assign done = done_q;
   assign init_done = init_q;
   assign cur_iface = cur_if_q;
   assign cur_tm = cur_tm_q;
endmodule

// file: nim_pkg.sv
// Shared constants and types for the interface mode selection link
// Notes on behaviour
// - Power-on leaves every target in async mode
// - Each target keeps its own interface selection
// - Host resyncs a target with the async sequence
// - Async return: deselect, stop clock, then reset
// - Reset holds ready/busy low for reset time
// - Async entered after change time; status only
// - Reset end: ready high, first param zero
// - First param upper nibble one selects NV-DDR
// - Sync select: busy for change time, host idle
// - After change time NV-DDR runs, ready high
// - Host starts clock before selecting target again
// - No direct switch between the two sync modes
// - Host writes NV-DDR2 configuration before selecting
// - Configuration changes only while not in NV-DDR2; the device writes it in any interface mode
// - First param upper nibble two selects NV-DDR2
// - After change time NV-DDR2 runs, ready high
// - Command decoding identical in every interface mode
// - Host resets each target first, never twice busy
package nim_pkg;
   localparam int NT = 2;
   localparam int TW = 1;
   typedef enum logic [1:0] {
      NIM_IF_ASYNC = 2'b00,
      NIM_IF_NVDDR = 2'b01,
      NIM_IF_NVDDR2 = 2'b10
   } nim_iface_e;
   typedef enum logic [1:0] {
      NIM_PH_RST = 2'b00,
      NIM_PH_CFG = 2'b01,
      NIM_PH_SEL = 2'b10
   } nim_phase_e;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] FEAT_TIMING = 8'h01;
   localparam logic [7:0] FEAT_NV2_CFG = 8'h02;
   localparam logic [7:0] P1_ASYNC_TM0 = 8'h00;
   localparam logic [3:0] P1_SEL_NVDDR = 4'h1;
   localparam logic [3:0] P1_SEL_NVDDR2 = 4'h2;
   localparam logic [3:0] RST_TM = 4'h0;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam int LINK_PERIOD_NS = 80;
   localparam int T_RST_NS = 2000;
   localparam int T_ITC_NS = 1000;
   localparam logic [7:0] RST_CYC = 8'((T_RST_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [7:0] ITC_CYC = 8'((T_ITC_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [7:0] STROBE_CYC = 8'h10;
   localparam logic [7:0] CE_SETUP_CYC = 8'h08;
   localparam logic [1:0] CLK_DIV = 2'h2;
   localparam logic [3:0] CLK_IDLE_CYC = 4'h8;
endpackage

// file: nim_link_if.sv
// Pins between flash host controller and flash targets
`timescale 1ns/1ps
interface nim_link_if;
   logic [nim_pkg::NT-1:0] ce_n;
   logic cle;
   logic ale;
   logic we_n;
   logic [7:0] dq;
   logic nand_clk;
   logic [nim_pkg::NT-1:0] rb_n;
   modport dev (input ce_n, input cle, input ale, input we_n, input dq, input nand_clk,
      output rb_n);
   modport host (output ce_n, output cle, output ale, output we_n, output dq,
      output nand_clk, input rb_n);
endinterface

// file: nim_dev.sv
// Flash device end: per-target interface mode selection
`timescale 1ns/1ps
module nim_dev (
   input wire logic clk_link,
   input wire logic rst_b,
   nim_link_if.dev link,
   output logic [nim_pkg::NT-1:0][1:0] iface_mode,
   output logic [nim_pkg::NT-1:0][3:0] timing_mode_index,
   output logic [nim_pkg::NT-1:0][7:0] feature_param_first,
   output logic dev_clk_active
);
   import nim_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FADDR = 3'b001,
      ST_FDATA = 3'b010,
      ST_BUSY_RST = 3'b011,
      ST_BUSY_ITC = 3'b100
   } nim_dstate_e;

   logic [NT-1:0] ce_m_q, ce_s_q;
   logic [11:0] pin_m_q, pin_s_q;
   logic we_d_q;
   logic clk_d_q;
   logic [3:0] act_q;
   logic strobe;
   logic cmd_cyc;
   logic adr_cyc;
   logic [7:0] dq_s;

   // Pins are asynchronous to this domain
   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         ce_m_q <= '1;
         ce_s_q <= '1;
         // Write strobe idles high so no false edge follows reset
         pin_m_q <= 12'h400;
         pin_s_q <= 12'h400;
      end else begin
         ce_m_q <= link.ce_n;
         ce_s_q <= ce_m_q;
         pin_m_q <= {link.nand_clk, link.we_n, link.cle, link.ale, link.dq};
         pin_s_q <= pin_m_q;
      end
   end

   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         we_d_q <= 1'b1;
         clk_d_q <= 1'b0;
         act_q <= 4'h0;
      end else begin
         we_d_q <= pin_s_q[10];
         clk_d_q <= pin_s_q[11];
         if (pin_s_q[11] != clk_d_q) begin
            act_q <= CLK_IDLE_CYC;
         end else if (act_q != 4'h0) begin
            act_q <= act_q - 4'h1;
         end
      end
   end

   // Latch on rising write strobe; data is held stable across it
   assign strobe = pin_s_q[10] && !we_d_q;
   assign cmd_cyc = strobe && pin_s_q[9];
   assign adr_cyc = strobe && pin_s_q[8];
   assign dq_s = pin_s_q[7:0];
   assign dev_clk_active = (act_q != 4'h0);

   // Every target has private state; only its own select opens it
   for (genvar t = 0; t < NT; t++) begin : g_tgt
      nim_dstate_e st_q;
      nim_iface_e if_q, pend_q;
      logic [3:0] tm_q, pend_tm_q;
      logic [7:0] p1_q, fp1_q, faddr_q, cfg_q, cnt_q;
      logic [1:0] fidx_q;
      logic nz_q;
      logic rb_q;
      logic sel;
      logic nz_all;

      assign sel = !ce_s_q[t];
      assign nz_all = nz_q || (dq_s != 8'h00);

      always_ff @(posedge clk_link or negedge rst_b) begin
         if (!rst_b) begin
            st_q <= ST_IDLE;
            if_q <= NIM_IF_ASYNC;
            pend_q <= NIM_IF_ASYNC;
            tm_q <= RST_TM;
            pend_tm_q <= RST_TM;
            p1_q <= P1_ASYNC_TM0;
            fp1_q <= P1_ASYNC_TM0;
            faddr_q <= 8'h00;
            cfg_q <= RST_CFG;
            cnt_q <= 8'h00;
            fidx_q <= 2'h0;
            nz_q <= 1'b0;
            rb_q <= 1'b1;
         end else begin
            case (st_q)
               ST_IDLE, ST_FADDR, ST_FDATA: begin
                  if (sel && cmd_cyc && dq_s == CMD_RESET) begin
                     st_q <= ST_BUSY_RST;
                     cnt_q <= 8'h00;
                     rb_q <= 1'b0;
                  end else if (sel && cmd_cyc && dq_s == CMD_SET_FEATURES) begin
                     st_q <= ST_FADDR;
                  end else if (sel && cmd_cyc) begin
                     // Status and unhandled commands leave the mode alone
                     st_q <= ST_IDLE;
                  end else if (sel && adr_cyc && st_q == ST_FADDR) begin
                     faddr_q <= dq_s;
                     fidx_q <= 2'h0;
                     nz_q <= 1'b0;
                     st_q <= ST_FDATA;
                  end else if (sel && strobe && st_q == ST_FDATA) begin
                     fidx_q <= fidx_q + 2'h1;
                     if (fidx_q == 2'h0) begin
                        fp1_q <= dq_s;
                     end else begin
                        nz_q <= nz_all;
                     end
                     if (fidx_q == 2'h3) begin
                        st_q <= ST_IDLE;
                        if (faddr_q == FEAT_NV2_CFG) begin
                           cfg_q <= fp1_q;
                        end else if (faddr_q == FEAT_TIMING && !nz_all) begin
                           // Switch between the two sync modes is refused; target stays ready
                           if (fp1_q[7:4] == P1_SEL_NVDDR && if_q != NIM_IF_NVDDR2) begin
                              pend_q <= NIM_IF_NVDDR;
                              pend_tm_q <= fp1_q[3:0];
                              st_q <= ST_BUSY_ITC;
                              cnt_q <= 8'h00;
                              rb_q <= 1'b0;
                           end else if (fp1_q[7:4] == P1_SEL_NVDDR2 &&
                              if_q != NIM_IF_NVDDR) begin
                              pend_q <= NIM_IF_NVDDR2;
                              pend_tm_q <= fp1_q[3:0];
                              st_q <= ST_BUSY_ITC;
                              cnt_q <= 8'h00;
                              rb_q <= 1'b0;
                           end
                        end
                     end
                  end
               end
               ST_BUSY_RST: begin
                  // Only status reads are legal here and they change nothing
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == ITC_CYC - 8'h01) begin
                     if_q <= NIM_IF_ASYNC;
                  end
                  if (cnt_q == RST_CYC - 8'h01) begin
                     rb_q <= 1'b1;
                     p1_q <= P1_ASYNC_TM0;
                     tm_q <= RST_TM;
                     st_q <= ST_IDLE;
                  end
               end
               ST_BUSY_ITC: begin
                  // Commands during the change time are ignored
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == ITC_CYC - 8'h01) begin
                     if_q <= pend_q;
                     tm_q <= pend_tm_q;
                     p1_q <= fp1_q;
                     rb_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end

      assign link.rb_n[t] = rb_q;
      assign iface_mode[t] = if_q;
      assign timing_mode_index[t] = tm_q;
      assign feature_param_first[t] = p1_q;
   end
endmodule

// file: nim_link_asserts.sv
// Concurrent checks on the pins between host and flash targets
`timescale 1ns/1ps
module nim_link_asserts (
   input wire logic clk_sys,
   input wire logic clk_link,
   input wire logic rst_b,
   input wire logic [nim_pkg::NT-1:0] ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic [7:0] dq,
   input wire logic nand_clk,
   input wire logic [nim_pkg::NT-1:0] rb_n
);
   import nim_pkg::*;
   logic [7:0] busy_q;
   logic [7:0] last_cmd_q;
   logic we_q;
   // Busy length counted in link cycles, cleared when ready
   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 8'h00;
      end else if (rb_n != 2'h3) begin
         busy_q <= busy_q + 8'h01;
      end else begin
         busy_q <= 8'h00;
      end
   end
   // Last command byte, so a busy span can be tied to its cause
   always_ff @(posedge clk_link or negedge rst_b) begin
      if (!rst_b) begin
         last_cmd_q <= 8'h00;
         we_q <= 1'h1;
      end else begin
         we_q <= we_n;
         if (we_n && !we_q && cle) begin
            last_cmd_q <= dq;
         end
      end
   end
   property p_no_strobe_busy;
      @(posedge clk_sys) disable iff (!rst_b)
      (rb_n != 2'h3) |-> we_n;
   endproperty
   a_no_strobe_busy: assert property (p_no_strobe_busy)
      else $error("Write strobe while a target is busy");
   property p_one_target;
      @(posedge clk_sys) disable iff (!rst_b)
      !we_n |-> $onehot(~ce_n);
   endproperty
   a_one_target: assert property (p_one_target)
      else $error("Strobe not aimed at exactly one target");
   property p_clk_stop;
      @(posedge clk_sys) disable iff (!rst_b)
      (!we_n && cle && dq == CMD_RESET) |-> (!nand_clk && $stable(nand_clk));
   endproperty
   a_clk_stop: assert property (p_clk_stop)
      else $error("Link clock running during reset command");
   property p_cmd_set;
      @(posedge clk_sys) disable iff (!rst_b)
      (!we_n && cle) |-> (dq == CMD_RESET || dq == CMD_SET_FEATURES);
   endproperty
   a_cmd_set: assert property (p_cmd_set)
      else $error("Unexpected command byte");
   property p_feat_addr;
      @(posedge clk_sys) disable iff (!rst_b)
      (!we_n && ale) |-> (dq == FEAT_TIMING || dq == FEAT_NV2_CFG);
   endproperty
   a_feat_addr: assert property (p_feat_addr)
      else $error("Unexpected feature address");
   property p_flags_excl;
      @(posedge clk_sys) disable iff (!rst_b)
      !(cle && ale);
   endproperty
   a_flags_excl: assert property (p_flags_excl)
      else $error("Command and address flags both high");
   property p_busy_start;
      @(posedge clk_link) disable iff (!rst_b)
      ($rose(we_n) && cle && dq == CMD_RESET && ce_n != 2'h3 && rb_n == 2'h3)
         |-> ##[1:6] (rb_n != 2'h3);
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("No busy after reset command");
   property p_rst_busy_len;
      @(posedge clk_link) disable iff (!rst_b)
      ($rose(rb_n == 2'h3) && last_cmd_q == CMD_RESET) |-> (busy_q == RST_CYC);
   endproperty
   a_rst_busy_len: assert property (p_rst_busy_len)
      else $error("Reset busy span has the wrong length");
   property p_sel_busy_len;
      @(posedge clk_link) disable iff (!rst_b)
      ($rose(rb_n == 2'h3) && last_cmd_q != CMD_RESET) |-> (busy_q == ITC_CYC);
   endproperty
   a_sel_busy_len: assert property (p_sel_busy_len)
      else $error("Select busy span has the wrong length");
endmodule

// file: test_nand_interface_mode_select.sv
// Self-checking bench: host and device ends joined by the link
`timescale 1ns/1ps
module test_nand_interface_mode_select;
   import nim_pkg::*;
   typedef struct packed {
      logic [1:0][1:0] ifc;
      logic [1:0][3:0] tm;
   } nim_note_s;
   logic clk_sys = 1'h0;
   logic clk_link = 1'h0;
   logic rst_b = 1'h0;
   logic req_valid = 1'h0;
   nim_iface_e req_iface = NIM_IF_ASYNC;
   logic [TW-1:0] req_target = 1'h0;
   logic [3:0] req_tm = 4'h0;
   logic [7:0] req_cfg = 8'h00;
   logic req_ready, done, init_done, dev_clk_active;
   logic [NT-1:0][1:0] cur_iface, iface_mode;
   logic [NT-1:0][3:0] cur_tm, timing_mode_index;
   logic [NT-1:0][7:0] feature_param_first;
   int bad_count = 0;
   int checks = 0;
   logic [31:0] rng = 32'h0000_0039;
   nim_note_s mdl = '0;
   nim_note_s notes[$];
   nim_iface_e fix_if[6] = '{NIM_IF_NVDDR, NIM_IF_NVDDR2, NIM_IF_NVDDR2, NIM_IF_NVDDR2,
      NIM_IF_ASYNC, NIM_IF_NVDDR};
   logic fix_t[6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
   nim_link_if lnk();
   // Half periods of 20 and 40 ns keep the two rising clock edges apart
   always #20 clk_sys = ~clk_sys;
   always #40 clk_link = ~clk_link;
   nim_host nim_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(lnk),
      .req_valid(req_valid), .req_iface(req_iface), .req_target(req_target),
      .req_tm(req_tm), .req_cfg(req_cfg), .req_ready(req_ready), .done(done),
      .init_done(init_done), .cur_iface(cur_iface), .cur_tm(cur_tm));
   nim_dev nim_dev_inst (.clk_link(clk_link), .rst_b(rst_b), .link(lnk),
      .iface_mode(iface_mode), .timing_mode_index(timing_mode_index),
      .feature_param_first(feature_param_first), .dev_clk_active(dev_clk_active));
   nim_link_asserts nim_link_asserts_inst (.clk_sys(clk_sys), .clk_link(clk_link),
      .rst_b(rst_b), .ce_n(lnk.ce_n), .cle(lnk.cle), .ale(lnk.ale), .we_n(lnk.we_n),
      .dq(lnk.dq), .nand_clk(lnk.nand_clk), .rb_n(lnk.rb_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] exp_p1(input logic [1:0] f, input logic [3:0] tm);
      if (f == NIM_IF_NVDDR) begin
         return {P1_SEL_NVDDR, tm};
      end else if (f == NIM_IF_NVDDR2) begin
         return {P1_SEL_NVDDR2, tm};
      end
      return P1_ASYNC_TM0;
   endfunction
   task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_all(input nim_note_s n);
      for (int t = 0; t < NT; t++) begin
         chk_val("host mode", 8'(n.ifc[t]), 8'(cur_iface[t]));
         chk_val("host tm", 8'(n.tm[t]), 8'(cur_tm[t]));
         chk_val("dev mode", 8'(n.ifc[t]), 8'(iface_mode[t]));
         chk_val("dev tm", 8'(n.tm[t]), 8'(timing_mode_index[t]));
         chk_val("dev p1", exp_p1(n.ifc[t], n.tm[t]), feature_param_first[t]);
      end
   endtask
   task automatic tally_and_finish;
      $display("Counts: %0d comparisons, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One switch request; a stray request during the sequence must be ignored
   task automatic do_req(input logic t, input nim_iface_e f, input logic [3:0] tm,
      input logic [7:0] cfg);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'h1;
      req_target <= t;
      req_iface <= f;
      req_tm <= tm;
      req_cfg <= cfg;
      do begin
         @(posedge clk_sys);
         n++;
      end while (req_ready !== 1'h1 && n < 5000);
      req_valid <= 1'h0;
      mdl.ifc[t] = f;
      mdl.tm[t] = (f == NIM_IF_ASYNC) ? 4'h0 : tm;
      notes.push_back(mdl);
      @(posedge clk_sys);
      req_valid <= 1'h1;
      req_target <= ~t;
      req_iface <= NIM_IF_NVDDR2;
      repeat (8) @(posedge clk_sys);
      req_valid <= 1'h0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (done !== 1'h1 && n < 5000);
      chk_val("done seen", 8'h01, 8'(done));
      // Clock activity needs several link cycles to be seen by the device
      repeat (40) @(posedge clk_sys);
      chk_val("dev clock", 8'(f != NIM_IF_ASYNC), 8'(dev_clk_active));
      $display("test done: target %0d mode %0d tm %0d", t, f, tm);
   endtask
   // Result watcher: each done pulse consumes the oldest note
   always @(posedge clk_sys) begin
      if (done === 1'h1) begin
         if (notes.size() == 0) begin
            chk_val("unexpected done", 8'h00, 8'h01);
         end else begin
            cmp_all(notes.pop_front());
         end
      end
   end
   initial begin
      int n;
      n = 0;
      repeat (2) @(posedge clk_link);
      @(posedge clk_sys);
      rst_b <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (init_done !== 1'h1 && n < 5000);
      cmp_all(mdl);
      $display("test done: power-on state");
      // NV-DDR, second target NV-DDR2, direct sync switch, tm change, back to async
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         do_req(fix_t[i], fix_if[i], rng[7:4], rng[23:16]);
      end
      for (int i = 0; i < 10; i++) begin
         rng = xs(rng);
         do_req(rng[0], nim_iface_e'(2'(rng[9:8] % 2'h3)), rng[7:4], rng[23:16]);
      end
      tally_and_finish();
   end
   // Sixteen requests take well under this span
   initial begin
      repeat (60000) @(posedge clk_sys);
      chk_val("watchdog", 8'h00, 8'h01);
      tally_and_finish();
   end
endmodule
